// ---- verilog/monitor_port_select_port_mux.v ----
/*
 network monitor port mirror: one host register picks a switch port whose raw
 phy-side pins are copied to seven monitor pins, serial or nibble layout.
 assumes a same-clock host access port and port pins straight from the phys.
*/
// Behaviour
// - select code is low nibble at 0xA2
// - codes 0..14 pick port, 15 disables
// - serial layout gives seven serial-interface signals
// - nibble bit 0 uses fixed serial order
// - wide transmit: data, enable, clock, speed
// - wide receive: data, valid, clock, speed
// - ports 3..14 wide: upper data undriven
// - direction bit picks receive or transmit
// - mirror raw phy pins before mac
// - receive signals reach the pins three mclk stages late
// - transmit signals pass through unregistered
// - register reached through host access port
`timescale 1ns/10ps
`include "monitor_port_select_defines.vh"
module monitor_port_select_port_mux (
  input wire mclk_i,
  input wire rst_n_i,
  input wire host_cs_i,
  input wire host_wr_i,
  input wire [7:0] host_addr_i,
  input wire [7:0] host_wdata_i,
  output reg [7:0] host_rdata_o,
  input wire [59:0] port_receive_data_i,
  input wire [14:0] port_receive_clock_i,
  input wire [14:0] port_receive_valid_i,
  input wire [14:0] port_carrier_sense_i,
  input wire [14:0] port_collision_i,
  input wire [59:0] port_transmit_data_i,
  input wire [14:0] port_transmit_clock_i,
  input wire [14:0] port_transmit_enable_i,
  input wire [14:0] port_speed_indicator_i,
  output reg monitor_out_0_o,
  output reg monitor_out_1_o,
  output reg monitor_out_2_o,
  output reg monitor_out_3_o,
  output reg monitor_out_4_o,
  output reg monitor_out_5_o,
  output reg monitor_out_6_o,
  output reg monitor_upper_oe_o
);
  reg [7:0] network_monitor;
  wire [3:0] code;
  wire monitor_direction_select;
  wire monitor_nibble_width;
  wire enabled;
  wire narrow_port;
  reg [3:0] sel_rxd;
  reg sel_rclk;
  reg sel_rxdv;
  reg sel_crs;
  reg sel_col;
  reg sel_speed;
  reg [3:0] sel_txd;
  reg sel_tclk;
  reg sel_txen;
  wire [3:0] cap_rxd;
  wire cap_rxdv;
  wire cap_crs;
  wire cap_col;
  wire cap_speed;
  wire cap_rclk;
  integer i;

  function [3:0] nib;
    input [59:0] bus;
    input [3:0] idx;
    integer k;
    begin
      nib = 4'h0;
      for (k = 0; k < `MONITOR_PORT_SELECT_PORTS; k = k + 1) begin
        if (idx == k[3:0]) begin
          nib = bus[k*`MONITOR_PORT_SELECT_NIB_W +: `MONITOR_PORT_SELECT_NIB_W];
        end
      end
    end
  endfunction

  assign code = network_monitor[`MONITOR_PORT_SELECT_CODE_MSB:`MONITOR_PORT_SELECT_CODE_LSB];
  assign monitor_direction_select = network_monitor[`MONITOR_PORT_SELECT_DIR_BIT];
  assign monitor_nibble_width = network_monitor[`MONITOR_PORT_SELECT_WIDE_BIT];
  assign enabled = (code != `MONITOR_PORT_SELECT_CODE_OFF);
  assign narrow_port = (code > `MONITOR_PORT_SELECT_LAST_SNI_PORT);

  // host access port: write taken on the mclk edge, read data a cycle later
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      network_monitor <= `MONITOR_PORT_SELECT_REG_RESET;
      host_rdata_o <= 8'h00;
    end else begin
      host_rdata_o <= 8'h00;
      if (host_cs_i && host_addr_i == `MONITOR_PORT_SELECT_REG_ADDR) begin
        if (host_wr_i) begin
          network_monitor <= host_wdata_i & `MONITOR_PORT_SELECT_REG_MASK;
        end else begin
          host_rdata_o <= network_monitor;
        end
      end
    end
  end

  // raw phy-side pins of the chosen port, nothing from the mac
  always @* begin
    sel_rclk = 1'b0;
    sel_rxdv = 1'b0;
    sel_crs = 1'b0;
    sel_col = 1'b0;
    sel_speed = 1'b0;
    sel_tclk = 1'b0;
    sel_txen = 1'b0;
    for (i = 0; i < `MONITOR_PORT_SELECT_PORTS; i = i + 1) begin
      if (code == i[3:0]) begin
        sel_rclk = port_receive_clock_i[i];
        sel_rxdv = port_receive_valid_i[i];
        sel_crs = port_carrier_sense_i[i];
        sel_col = port_collision_i[i];
        sel_speed = port_speed_indicator_i[i];
        sel_tclk = port_transmit_clock_i[i];
        sel_txen = port_transmit_enable_i[i];
      end
    end
    sel_rxd = nib(port_receive_data_i, code);
    sel_txd = nib(port_transmit_data_i, code);
  end

  monitor_port_select_rx_capture u_rx (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .rclk_i(sel_rclk),
    .rxd_i(sel_rxd),
    .rxdv_i(sel_rxdv),
    .crs_i(sel_crs),
    .col_i(sel_col),
    .speed_i(sel_speed),
    .rxd_o(cap_rxd),
    .rxdv_o(cap_rxdv),
    .crs_o(cap_crs),
    .col_o(cap_col),
    .speed_o(cap_speed),
    .rclk_o(cap_rclk)
  );

  // transmit side stays combinational so it tracks the port's own pins;
  // registering it in mclk would add jitter the probe cannot remove
  always @* begin
    monitor_out_0_o = 1'b0;
    monitor_out_1_o = 1'b0;
    monitor_out_2_o = 1'b0;
    monitor_out_3_o = 1'b0;
    monitor_out_4_o = 1'b0;
    monitor_out_5_o = 1'b0;
    monitor_out_6_o = 1'b0;
    monitor_upper_oe_o = 1'b1;
    if (enabled) begin
      if (!monitor_nibble_width) begin
        monitor_out_0_o = cap_rxd[0];
        monitor_out_1_o = cap_crs;
        monitor_out_2_o = cap_rclk;
        monitor_out_3_o = sel_txd[0];
        monitor_out_4_o = sel_txen;
        monitor_out_5_o = sel_tclk;
        monitor_out_6_o = cap_col;
      end else if (monitor_direction_select) begin
        monitor_out_0_o = sel_txd[0];
        monitor_out_1_o = sel_txd[1];
        monitor_out_2_o = sel_txd[2];
        monitor_out_3_o = sel_txd[3];
        monitor_out_4_o = sel_txen;
        monitor_out_5_o = sel_tclk;
        monitor_out_6_o = sel_speed;
        monitor_upper_oe_o = ~narrow_port;
      end else begin
        monitor_out_0_o = cap_rxd[0];
        monitor_out_1_o = cap_rxd[1];
        monitor_out_2_o = cap_rxd[2];
        monitor_out_3_o = cap_rxd[3];
        monitor_out_4_o = cap_rxdv;
        monitor_out_5_o = cap_rclk;
        monitor_out_6_o = cap_speed;
        monitor_upper_oe_o = ~narrow_port;
      end
      if (monitor_nibble_width && narrow_port) begin
        monitor_out_1_o = 1'b0;
        monitor_out_2_o = 1'b0;
        monitor_out_3_o = 1'b0;
      end
    end
  end
endmodule

// ---- verilog/monitor_port_select_defines.vh ----
/*
 constants for the network monitor port mirror: host register map, field
 positions, reset value and port geometry. assumes inclusion by design files.
*/
`ifndef MONITOR_PORT_SELECT_DEFINES_VH
`define MONITOR_PORT_SELECT_DEFINES_VH

`define MONITOR_PORT_SELECT_ADDR_W 8
`define MONITOR_PORT_SELECT_DATA_W 8
`define MONITOR_PORT_SELECT_REG_ADDR 8'hA2
`define MONITOR_PORT_SELECT_REG_RESET 8'h0F
`define MONITOR_PORT_SELECT_CODE_MSB 3
`define MONITOR_PORT_SELECT_CODE_LSB 0
`define MONITOR_PORT_SELECT_DIR_BIT 4
`define MONITOR_PORT_SELECT_WIDE_BIT 5
`define MONITOR_PORT_SELECT_REG_MASK 8'h3F
`define MONITOR_PORT_SELECT_CODE_OFF 4'hF
`define MONITOR_PORT_SELECT_PORTS 15
`define MONITOR_PORT_SELECT_NIB_W 4
`define MONITOR_PORT_SELECT_LAST_SNI_PORT 4'h2

`endif

// ---- verilog/monitor_port_select_rx_capture.v ----
/*
 receive-side capture for the monitor mirror: brings the selected port's
 receive pins into the mclk domain and latches them on each rising edge of
 that port's receive clock. assumes the receive clock is well below mclk/2.
*/
`timescale 1ns/10ps
module monitor_port_select_rx_capture (
  input wire mclk_i,
  input wire rst_n_i,
  input wire rclk_i,
  input wire [3:0] rxd_i,
  input wire rxdv_i,
  input wire crs_i,
  input wire col_i,
  input wire speed_i,
  output reg [3:0] rxd_o,
  output reg rxdv_o,
  output reg crs_o,
  output reg col_o,
  output reg speed_o,
  output reg rclk_o
);
  reg [8:0] meta;
  reg [8:0] sync;
  reg rclk_d;
  wire rise;

  // first stage feeds only the second stage
  assign rise = sync[8] & ~rclk_d;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 9'h000;
      sync <= 9'h000;
      rclk_d <= 1'b0;
      rxd_o <= 4'h0;
      rxdv_o <= 1'b0;
      crs_o <= 1'b0;
      col_o <= 1'b0;
      speed_o <= 1'b0;
      rclk_o <= 1'b0;
    end else begin
      meta <= {rclk_i, speed_i, col_i, crs_i, rxdv_i, rxd_i};
      sync <= meta;
      rclk_d <= sync[8];
      rclk_o <= sync[8];
      // held until the next receive clock edge: three mclk stages of delay, no receive clock
      if (rise) begin
        rxd_o <= sync[3:0];
        rxdv_o <= sync[4];
        crs_o <= sync[5];
        col_o <= sync[6];
        speed_o <= sync[7];
      end
    end
  end
endmodule

// ---- tb/monitor_port_select_sva.sv ----
/* assertions on the host read data and the mirror pins; host writes are shadowed to know the mode */
`timescale 1ns/10ps
module monitor_port_select_sva (
  input wire mclk_i, input wire rst_n_i, input wire host_cs_i, input wire host_wr_i,
  input wire [7:0] host_addr_i, input wire [7:0] host_wdata_i, input wire [7:0] host_rdata_o,
  input wire [59:0] port_transmit_data_i, input wire [14:0] port_transmit_clock_i,
  input wire [14:0] port_transmit_enable_i, input wire [59:0] port_receive_data_i,
  input wire [14:0] port_receive_clock_i, input wire monitor_out_0_o,
  input wire monitor_out_1_o, input wire monitor_out_2_o, input wire monitor_out_3_o,
  input wire monitor_out_4_o, input wire monitor_out_5_o, input wire monitor_out_6_o,
  input wire monitor_upper_oe_o
);
  reg [5:0] sh;
  wire [3:0] p = sh[3:0];
  wire on = p != 4'hF;
  wire rd = host_cs_i && !host_wr_i && host_addr_i == 8'hA2;
  wire [3:0] mo = {monitor_out_3_o, monitor_out_2_o, monitor_out_1_o, monitor_out_0_o};
  wire [2:0] hi = {monitor_out_6_o, monitor_out_5_o, monitor_out_4_o};
  always @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      sh <= 6'h0F;
    else if (host_cs_i && host_wr_i && host_addr_i == 8'hA2)
      sh <= host_wdata_i[5:0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_read_back: assert property (rd |=> host_rdata_o == {2'h0, $past(sh)})
    else $error("read data wrong");
  chk_rdata_idle: assert property (!rd |=> host_rdata_o == 8'h00)
    else $error("read data not idle");
  chk_off_low: assert property (!on |-> mo == 4'h0 && hi == 3'h0)
    else $error("monitor off not low");
  chk_serial_tx: assert property (on && !sh[5] |-> monitor_out_3_o ==
    port_transmit_data_i[4*p] && monitor_out_4_o == port_transmit_enable_i[p])
    else $error("serial tx order");
  chk_wide_tx: assert property (on && sh[5:4] == 2'h3 && p < 4'h3 |->
    mo == port_transmit_data_i[4*p +: 4] && monitor_out_5_o == port_transmit_clock_i[p])
    else $error("wide tx order");
  chk_upper_off: assert property (on && sh[5] && p > 4'h2 |->
    !monitor_upper_oe_o && mo[3:1] == 3'h0)
    else $error("upper data driven");
  chk_rx_clock: assert property (on && sh[5:4] == 2'h2 &&
    $rose(port_receive_clock_i[p]) |-> ##[2:4] monitor_out_5_o)
    else $error("rx clock late");
  chk_rx_data: assert property (on && sh[5:4] == 2'h2 && p < 4'h3 &&
    $rose(monitor_out_5_o) |-> mo == $past(port_receive_data_i[4*p +: 4], 4))
    else $error("rx data wrong");
endmodule
bind monitor_port_select_port_mux monitor_port_select_sva chk (.*);

// ---- tb/monitor_port_select_probe.sv ----
/* probe on the mirror pins: counts rises of the mirrored clock, drives nothing */
`timescale 1ns/10ps
module monitor_port_select_probe (
  input wire mclk_i,
  input wire clk_pin_i,
  output reg [7:0] rises_o
);
  reg last = 1'b0;
  initial rises_o = 8'h00;
  always @(posedge mclk_i) begin
    if (clk_pin_i && !last)
      rises_o <= rises_o + 8'h01;
    last <= clk_pin_i;
  end
endmodule

// ---- tb/tb_network_monitor_port_mux.sv ----
/* bench for the mirror: host cycles, port pin stimulus, probe on the pins */
`timescale 1ns/10ps
module tb_network_monitor_port_mux;
  reg mclk_i = 0, rst_n_i = 0, host_cs_i = 0, host_wr_i = 0;
  reg [7:0] host_addr_i = 0, host_wdata_i = 0, base;
  reg [59:0] port_receive_data_i = 0, port_transmit_data_i = 0;
  reg [14:0] port_receive_clock_i = 0, port_receive_valid_i = 0, port_carrier_sense_i = 0;
  reg [14:0] port_collision_i = 0, port_transmit_clock_i = 0, port_transmit_enable_i = 0;
  reg [14:0] port_speed_indicator_i = 0;
  wire [7:0] host_rdata_o, rises;
  wire monitor_out_0_o, monitor_out_1_o, monitor_out_2_o, monitor_out_3_o;
  wire monitor_out_4_o, monitor_out_5_o, monitor_out_6_o, monitor_upper_oe_o;
  wire [6:0] mo = {monitor_out_6_o, monitor_out_5_o, monitor_out_4_o, monitor_out_3_o,
    monitor_out_2_o, monitor_out_1_o, monitor_out_0_o};
  integer n_fail = 0, n_checks = 0, k;
  monitor_port_select_port_mux dut (.*);
  monitor_port_select_probe probe (.mclk_i(mclk_i), .clk_pin_i(monitor_out_5_o), .rises_o(rises));
  task ck(input ok, input [8*12:1] m);
    begin
      n_checks = n_checks + 1;
      if (ok !== 1'b1) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t %0s", $time, m);
      end
    end
  endtask
  task hx(input w, input [7:0] a, input [7:0] d, input [7:0] e);
    begin
      @(negedge mclk_i);
      {host_cs_i, host_wr_i, host_addr_i, host_wdata_i} = {1'b1, w, a, d};
      @(negedge mclk_i);
      host_cs_i = 0;
      if (!w)
        ck(host_rdata_o === e, "read data");
    end
  endtask
  task t_reg;
    begin
      hx(0, 8'hA2, 0, 8'h0F);
      port_transmit_data_i = ~60'h0;
      port_transmit_enable_i = ~15'h0;
      hx(1, 8'hA2, 8'hFF, 0);
      ck(mo === 7'h00, "off");
      hx(0, 8'hA2, 0, 8'h3F);
      hx(0, 8'hA0, 0, 8'h00);
      $display("t_reg done");
    end
  endtask
  task t_map;
    for (k = 0; k < 15; k = k + 1) begin
      port_transmit_enable_i = 15'h1 << k;
      port_transmit_clock_i = port_transmit_enable_i;
      port_transmit_data_i = 60'h1 << (4 * k);
      hx(1, 8'hA2, k[7:0], 0);
      ck(mo[5:3] === 3'h7, "serial");
      port_transmit_enable_i = ~port_transmit_enable_i;
      port_transmit_clock_i = ~port_transmit_clock_i;
      port_transmit_data_i = ~port_transmit_data_i;
      #1 ck(mo[5:3] === 3'h0, "pass");
    end
    $display("t_map done");
  endtask
  task t_ser;
    begin
      hx(1, 8'hA2, 8'h04, 0);
      port_receive_data_i[16] = 1;
      port_carrier_sense_i[4] = 1;
      port_collision_i[4] = 1;
      repeat (10) @(negedge mclk_i);
      port_receive_clock_i[4] = 1;
      repeat (10) @(negedge mclk_i);
      ck(mo === 7'h47, "serial rx");
      ck(monitor_upper_oe_o === 1'b1, "serial oe");
      port_receive_clock_i[4] = 0;
      $display("t_ser done");
    end
  endtask
  task t_txw;
    begin
      port_transmit_data_i = 60'h0000000001000A0;
      port_transmit_enable_i = 15'h2;
      port_transmit_clock_i = 15'h2;
      port_speed_indicator_i = 15'h2;
      hx(1, 8'hA2, 8'h31, 0);
      ck(mo === 7'h7A, "wide tx");
      hx(1, 8'hA2, 8'h35, 0);
      ck(monitor_upper_oe_o === 1'b0 && mo[3:0] === 4'h1, "upper");
      $display("t_txw done");
    end
  endtask
  task t_rxw;
    begin
      port_speed_indicator_i = 15'h4;
      hx(1, 8'hA2, 8'h22, 0);
      base = rises;
      for (k = 1; k < 5; k = k + 1) begin
        port_receive_data_i[11:8] = k;
        port_receive_valid_i[2] = k[0];
        repeat (10) @(negedge mclk_i);
        ck(mo[3:0] === k - 1, "rx hold");
        port_receive_clock_i[2] = 1;
        repeat (10) @(negedge mclk_i);
        ck(mo === {2'h3, k[0], k[3:0]}, "wide rx");
        port_receive_clock_i[2] = 0;
      end
      ck(rises - base === 8'h04, "rx clock");
      $display("t_rxw done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial forever #4 mclk_i = ~mclk_i;
  initial begin
    #100000;
    n_fail = n_fail + 1;
    end_sim;
  end
  initial begin
    repeat (16) @(negedge mclk_i);
    rst_n_i = 1;
    t_reg;
    t_map;
    t_txw;
    t_rxw;
    t_ser;
    end_sim;
  end
endmodule
